// ==== mdo_top.sv ====
// Magnetometer data-ready flags, sample registers and time-aligned acceleration
// Summary of operation
// - Axis overwrite flag is 1 when a new sample replaced an unread one.
// - Whole-set ready flag is 1 when a fresh three-axis acquisition exists.
// - Whole-set ready flag clears on reading the X, Y and Z high bytes.
// - Z ready sets on Z acquisition, clears on Z high-byte read.
// - Y ready sets on Y acquisition, clears on Y high-byte read.
// - X ready sets on X acquisition, clears on X high-byte read.
// - Each magnetic sample is 16-bit two's complement, 0.1 uT per LSB.
// - Magnetic outputs sit at 0x33 to 0x38, X Y Z, high byte first.
// - Decimated acceleration is 14-bit two's complement in read-only registers.
// - Decimated acceleration is captured together with each full three-axis magnetic set.
// - Decimation depends on output rate select and magnetic oversample ratio.
// - Acceleration set uses the same oversample ratio as the magnetic set.
// - Aligned acceleration is right justified within its byte pair.
// - Aligned acceleration bytes occupy 0x39 through 0x3E.
// - Whole-set overwrite sets on new set before read, clears on three high reads.
`timescale 1ns/1ps
module mdo_top #(
  parameter int MAG_W = mdo_pkg::MAG_W,
  parameter int ACC_W = mdo_pkg::ACC_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] mag_sample_valid,
  input wire logic [MAG_W-1:0] mag_sample_x,
  input wire logic [MAG_W-1:0] mag_sample_y,
  input wire logic [MAG_W-1:0] mag_sample_z,
  input wire logic acc_sample_valid,
  input wire logic [ACC_W-1:0] acc_sample_x,
  input wire logic [ACC_W-1:0] acc_sample_y,
  input wire logic [ACC_W-1:0] acc_sample_z,
  input wire logic [2:0] output_rate_select,
  input wire logic [2:0] mag_oversample_ratio,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rdata_ff,
  output logic [7:0] mag_ready_status_ff
);

  logic [MAG_W-1:0] mag_ff [3];
  logic [ACC_W-1:0] acc_ff [3];
  logic [ACC_W+3:0] acc_sum_ff [3];
  logic [3:0] dec_cnt_ff;
  logic [3:0] dec_len;
  logic [2:0] ready_ff;
  logic [2:0] over_ff;
  logic set_ready_ff;
  logic set_over_ff;
  logic [2:0] hi_read_ff;
  logic [2:0] hi_rd;
  logic [2:0] nxt_hi_read;
  logic set_done;
  logic [7:0] nxt_rdata;

  // High-byte read strobes per axis
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hi_rd[i] = reg_rd && (reg_addr == 8'(mdo_pkg::ADDR_MAG_X_HIGH + 8'(2 * i)));
    end
  end

  // Magnetic sample capture, 16-bit two's complement
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) mag_ff[i] <= mdo_pkg::MAG_RESET;
    end else begin
      if (mag_sample_valid[0]) mag_ff[0] <= mag_sample_x;
      if (mag_sample_valid[1]) mag_ff[1] <= mag_sample_y;
      if (mag_sample_valid[2]) mag_ff[2] <= mag_sample_z;
    end
  end

  // Axis ready and overwrite flags; a sample in the same cycle as a read sets ready and clears overwrite
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ready_ff <= 3'h0;
      over_ff <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (mag_sample_valid[i]) begin
          ready_ff[i] <= 1'b1;
          if (ready_ff[i] && !hi_rd[i]) over_ff[i] <= 1'b1;
          else if (hi_rd[i]) over_ff[i] <= 1'b0;
          else over_ff[i] <= over_ff[i];
        end else if (hi_rd[i]) begin
          ready_ff[i] <= 1'b0;
          over_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Tracks which high bytes were read since the whole set was last flagged
  always_comb begin
    nxt_hi_read = hi_read_ff | hi_rd;
    set_done = &nxt_hi_read;
  end

  // Whole-set ready and overwrite; a new full set beats a completing read for ready, the read clears overwrite
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      set_ready_ff <= 1'b0;
      set_over_ff <= 1'b0;
      hi_read_ff <= 3'h0;
    end else begin
      if (&mag_sample_valid) begin
        set_ready_ff <= 1'b1;
        hi_read_ff <= 3'h0;
        if (set_ready_ff && !set_done) set_over_ff <= 1'b1;
        else if (set_done) set_over_ff <= 1'b0;
      end else if (set_done) begin
        set_ready_ff <= 1'b0;
        set_over_ff <= 1'b0;
        hi_read_ff <= 3'h0;
      end else begin
        hi_read_ff <= nxt_hi_read;
      end
    end
  end

  // Decimation length from rate and oversample ratio, shared by all axes
  always_comb begin
    dec_len = 4'(output_rate_select) + 4'(mag_oversample_ratio);
    if (dec_len > mdo_pkg::DEC_MAX) dec_len = mdo_pkg::DEC_MAX;
  end

  // Acceleration accumulates the first dec_len plus one samples after a set; the sum divided by 16
  // is latched with the full magnetic set so both describe the same interval.
  // A fixed divide by 16 of the window sum is the mean only for a 16-sample
  // window; the shift keeps the divider out of the datapath.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dec_cnt_ff <= 4'h0;
      for (int i = 0; i < 3; i++) begin
        acc_sum_ff[i] <= '0;
        acc_ff[i] <= mdo_pkg::ACC_RESET;
      end
    end else begin
      if (&mag_sample_valid) begin
        for (int i = 0; i < 3; i++) begin
          acc_ff[i] <= acc_sum_ff[i][ACC_W+3:4];
          acc_sum_ff[i] <= '0;
        end
        dec_cnt_ff <= 4'h0;
      end else if (acc_sample_valid && dec_cnt_ff <= dec_len) begin
        acc_sum_ff[0] <= acc_sum_ff[0] + {{4{acc_sample_x[ACC_W-1]}}, acc_sample_x};
        acc_sum_ff[1] <= acc_sum_ff[1] + {{4{acc_sample_y[ACC_W-1]}}, acc_sample_y};
        acc_sum_ff[2] <= acc_sum_ff[2] + {{4{acc_sample_z[ACC_W-1]}}, acc_sample_z};
        dec_cnt_ff <= dec_cnt_ff + 4'h1;
      end
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      mdo_pkg::ADDR_STATUS: nxt_rdata = {set_over_ff, over_ff[2:0], set_ready_ff, ready_ff[2:0]};
      8'h33: nxt_rdata = mag_ff[0][15:8];
      8'h34: nxt_rdata = mag_ff[0][7:0];
      8'h35: nxt_rdata = mag_ff[1][15:8];
      8'h36: nxt_rdata = mag_ff[1][7:0];
      8'h37: nxt_rdata = mag_ff[2][15:8];
      8'h38: nxt_rdata = mag_ff[2][7:0];
      8'h39: nxt_rdata = {2'h0, acc_ff[0][13:8]};
      8'h3A: nxt_rdata = acc_ff[0][7:0];
      8'h3B: nxt_rdata = {2'h0, acc_ff[1][13:8]};
      8'h3C: nxt_rdata = acc_ff[1][7:0];
      8'h3D: nxt_rdata = {2'h0, acc_ff[2][13:8]};
      8'h3E: nxt_rdata = acc_ff[2][7:0];
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 8'h00;
      mag_ready_status_ff <= mdo_pkg::STATUS_RESET;
    end else begin
      if (reg_rd) reg_rdata_ff <= nxt_rdata;
      mag_ready_status_ff <= {set_over_ff, over_ff, set_ready_ff, ready_ff};
    end
  end

  a_x_ready_set: assert property (@(posedge mclk) disable iff (!rstn)
    mag_sample_valid[0] |=> ready_ff[0]) else $error("x ready not set");
  a_y_ready_set: assert property (@(posedge mclk) disable iff (!rstn)
    mag_sample_valid[1] |=> ready_ff[1]) else $error("y ready not set");
  a_z_ready_clr: assert property (@(posedge mclk) disable iff (!rstn)
    hi_rd[2] && !mag_sample_valid[2] |=> !ready_ff[2]) else $error("z ready not cleared");
  a_x_over_set: assert property (@(posedge mclk) disable iff (!rstn)
    ready_ff[0] && mag_sample_valid[0] && !hi_rd[0] |=> over_ff[0])
    else $error("x overwrite missed");
  a_set_ready: assert property (@(posedge mclk) disable iff (!rstn)
    &mag_sample_valid |=> set_ready_ff) else $error("set ready missing");
  a_set_clear: assert property (@(posedge mclk) disable iff (!rstn)
    set_done && !(&mag_sample_valid) |=> !set_ready_ff && !set_over_ff)
    else $error("set flags not cleared");
  a_set_hold: assert property (@(posedge mclk) disable iff (!rstn)
    set_ready_ff && !set_done && !(&mag_sample_valid) |=> set_ready_ff)
    else $error("set ready dropped early");
  a_acc_align: assert property (@(posedge mclk) disable iff (!rstn)
    !(&$past(mag_sample_valid)) |-> $stable(acc_ff[0])) else $error("accel moved alone");
  a_rdata_mag: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == mdo_pkg::ADDR_MAG_X_HIGH |=> reg_rdata_ff == $past(mag_ff[0][15:8]))
    else $error("x high byte wrong");
  a_acc_just: assert property (@(posedge mclk) disable iff (!rstn)
    reg_rd && reg_addr == mdo_pkg::ADDR_ACC_X_HIGH |=> reg_rdata_ff[7:6] == 2'h0)
    else $error("accel not right justified");
  c_full_set: cover property (@(posedge mclk) disable iff (!rstn) &mag_sample_valid);
  c_set_read: cover property (@(posedge mclk) disable iff (!rstn) set_ready_ff ##1 !set_ready_ff);
  c_overwrite: cover property (@(posedge mclk) disable iff (!rstn) set_over_ff);

endmodule : mdo_top

// ==== mdo_pkg.sv ====
// Package for the magnetometer data-ready and output block
package mdo_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h32;
  localparam logic [7:0] ADDR_MAG_X_HIGH = 8'h33;
  localparam logic [7:0] ADDR_MAG_X_LOW = 8'h34;
  localparam logic [7:0] ADDR_MAG_Y_HIGH = 8'h35;
  localparam logic [7:0] ADDR_MAG_Y_LOW = 8'h36;
  localparam logic [7:0] ADDR_MAG_Z_HIGH = 8'h37;
  localparam logic [7:0] ADDR_MAG_Z_LOW = 8'h38;
  localparam logic [7:0] ADDR_ACC_X_HIGH = 8'h39;
  localparam logic [7:0] ADDR_ACC_Z_LOW = 8'h3E;
  localparam int MAG_W = 16;
  localparam int ACC_W = 14;
  localparam int OSR_W = 3;
  localparam int RATE_W = 3;
  localparam logic [15:0] MAG_RESET = 16'h0000;
  localparam logic [13:0] ACC_RESET = 14'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BIT_XDR = 0;
  localparam int BIT_XYZDR = 3;
  localparam int BIT_XOW = 4;
  localparam int BIT_XYZOW = 7;
  localparam logic [3:0] DEC_MAX = 4'hF;
endpackage : mdo_pkg

// ==== mdo_host.sv ====
// Host model reading bytes on the register port
`timescale 1ns/1ps
module mdo_host (
  input wire logic mclk,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata_ff
);
  initial begin
    reg_rd = 1'b0;
    reg_addr = 8'h00;
  end
  // Released address is inverted so a stale value is never relied on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_ff;
  endtask : rd
endmodule : mdo_host

// ==== mag_data_ready_and_output_test.sv ====
// Self-checking bench for the magnetometer flags and output registers
`timescale 1ns/1ps
module mag_data_ready_and_output_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] mv = 3'h0;
  logic av = 1'b0;
  logic [15:0] ms [3] = '{16'h0, 16'h0, 16'h0};
  logic [13:0] acs [3] = '{14'h0, 14'h0, 14'h0};
  logic [15:0] mx [3] = '{16'h0, 16'h0, 16'h0};
  logic [13:0] ax [3] = '{14'h0, 14'h0, 14'h0};
  logic reg_rd;
  logic [7:0] reg_addr, reg_rdata_ff, st, d, r;
  logic [2:0] rdy = 3'h0, ow = 3'h0, seen = 3'h0;
  logic sr = 1'b0, so = 1'b0;
  logic [2:0] ors = 3'h7, osr = 3'h7;
  logic [15:0] lf = 16'h0041;
  int n_fail = 0;
  int checks = 0;
  always #25 mclk = ~mclk;
  mdo_top i_dut (.mclk(mclk), .rstn(rstn), .mag_sample_valid(mv), .mag_sample_x(ms[0]),
    .mag_sample_y(ms[1]), .mag_sample_z(ms[2]), .acc_sample_valid(av),
    .acc_sample_x(acs[0]), .acc_sample_y(acs[1]), .acc_sample_z(acs[2]),
    .output_rate_select(ors), .mag_oversample_ratio(osr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_ff(reg_rdata_ff), .mag_ready_status_ff(st));
  mdo_host i_host (.mclk(mclk), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_ff(reg_rdata_ff));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Window of rate plus ratio plus one equal samples, the sum divided by 16
  function automatic logic [13:0] acc_exp(input logic [13:0] v, input logic [4:0] n);
    return 14'((18'(v) * 18'(n)) >> 4);
  endfunction : acc_exp
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic stat();
    @(negedge mclk);
    chk("status", {so, ow, sr, rdy}, st);
  endtask : stat
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk("read data", e, d);
  endtask : rdb
  task automatic acc15();
    lf = nxt(lf);
    ors = lf[2:0];
    osr = lf[5:3];
    for (int i = 0; i < 3; i++) begin
      lf = nxt(lf);
      acs[i] = {2'h0, lf[11:0]};
    end
    repeat (15) begin
      @(negedge mclk);
      av = 1'b1;
      @(negedge mclk);
      av = 1'b0;
    end
  endtask : acc15
  task automatic pulse(input logic [2:0] v);
    @(negedge mclk);
    mv = v;
    for (int i = 0; i < 3; i++) begin
      lf = nxt(lf);
      ms[i] = lf;
      if (v[i]) mx[i] = lf;
      if (v == 3'h7) ax[i] = acc_exp(acs[i], 5'(ors) + 5'(osr) + 5'h1);
    end
    ow = ow | (rdy & v);
    rdy = rdy | v;
    if (v == 3'h7) begin
      so = so | sr;
      sr = 1'b1;
      seen = 3'h0;
    end
    @(negedge mclk);
    mv = 3'h0;
  endtask : pulse
  task automatic rdhi(input int i);
    rdb(mdo_pkg::ADDR_MAG_X_HIGH + 8'(2 * i), mx[i][15:8]);
    rdy[i] = 1'b0;
    ow[i] = 1'b0;
    seen[i] = 1'b1;
    if (seen == 3'h7) begin
      sr = 1'b0;
      so = 1'b0;
    end
  endtask : rdhi
  task automatic rdrest();
    for (int i = 0; i < 3; i++) begin
      rdb(mdo_pkg::ADDR_MAG_X_LOW + 8'(2 * i), mx[i][7:0]);
      rdb(mdo_pkg::ADDR_ACC_X_HIGH + 8'(2 * i), {2'h0, ax[i][13:8]});
      rdb(mdo_pkg::ADDR_ACC_X_HIGH + 8'(2 * i + 1), ax[i][7:0]);
    end
  endtask : rdrest
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    stat();
    rdrest();
    $display("test reset done");
    acc15();
    pulse(3'h7);
    acc15();
    pulse(3'h7);
    stat();
    // Z first: the whole-set flag must wait for all three
    for (int i = 2; i >= 0; i--) begin
      rdhi(i);
      stat();
    end
    rdrest();
    $display("test order done");
    repeat (24) begin
      lf = nxt(lf);
      r = lf[7:0];
      if (r[1:0] == 2'h0) begin
        acc15();
        pulse(3'h7);
      end else pulse(r[4:2] == 3'h7 ? 3'h2 : r[4:2]);
      stat();
      for (int i = 0; i < 3; i++) if (r[5 + i]) rdhi(i);
      stat();
      rdb(mdo_pkg::ADDR_STATUS, {so, ow, sr, rdy});
      rdb(8'h40, 8'h00);
    end
    rdrest();
    $display("test random done");
    end_of_test();
  end
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
endmodule : mag_data_ready_and_output_test
